// [pmsq_consts.svh]
/*
   sizes and reset values of the programmable mealy sequencer.
   assumes nothing; definitions only, included by bare name.
*/
`ifndef PMSQ_CONSTS_SVH
`define PMSQ_CONSTS_SVH

`define PMSQ_N_PTERMS 48
`define PMSQ_N_INPUTS 14
`define PMSQ_N_STATE 8
`define PMSQ_N_OUT 4
`define PMSQ_N_PIN_STATE 2
`define PMSQ_N_BASE_LITS 22
`define PMSQ_N_LITS 23
`define PMSQ_LINKS_PER_TERM 46
`define PMSQ_N_PAIRS 12
`define PMSQ_N_SR_SUMS 24
`define PMSQ_N_SUMS 25
`define PMSQ_C_SUM_IDX 24
`define PMSQ_C_LINK_LSB 44
`define PMSQ_STATE_RESET 8'hff
`define PMSQ_OUT_RESET 4'hf

`endif

// [pmsq_pkg.sv]
/*
   types shared by the sequencer planes and top.
   assumes pmsq_consts.svh is on the include path.
*/
`include "pmsq_consts.svh"

package pmsq_pkg;
   // one row of links per product term; bit 2k true literal, 2k+1 inverted
   typedef logic [`PMSQ_N_PTERMS-1:0][`PMSQ_LINKS_PER_TERM-1:0]
      pmsq_and_links_type;
   // one row per sum term, one link per product term
   typedef logic [`PMSQ_N_SUMS-1:0][`PMSQ_N_PTERMS-1:0] pmsq_or_links_type;
endpackage

// [pmsq_plane_if.sv]
/*
   signals between the sequencer top, its and plane and its or plane.
   assumes one clock domain; the clock rides along only for the checks.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"

interface pmsq_plane_if;
   logic clk;
   logic [`PMSQ_N_BASE_LITS-1:0] base_lits;
   logic c_lit;
   logic [`PMSQ_N_PTERMS-1:0] pterm_pre;
   logic [`PMSQ_N_PTERMS-1:0] pterm;
   logic [`PMSQ_N_PAIRS-1:0] sum_set;
   logic [`PMSQ_N_PAIRS-1:0] sum_rst;

   modport top_mp (output clk, output base_lits, input sum_set,
      input sum_rst);
   modport and_mp (input clk, input base_lits, input c_lit,
      output pterm_pre, output pterm);
   modport or_mp (input clk, input pterm_pre, input pterm, output sum_set,
      output sum_rst, output c_lit);
endinterface

// [pmsq_and_plane.sv]
/*
   programmable and plane: 48 product terms over 23 literals.
   assumes link bit high means the link is intact.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"

module pmsq_and_plane (
   // link map
   input wire pmsq_pkg::pmsq_and_links_type and_links_i,
   // plane signals
   pmsq_plane_if.and_mp pl
);

   logic [`PMSQ_N_LITS-1:0] lits;
   logic [`PMSQ_N_PTERMS-1:0] pre;
   logic [`PMSQ_N_PTERMS-1:0] fin;

   // a removed link leaves its input high at the gate
   function automatic logic term_of(input logic [`PMSQ_N_LITS-1:0] l,
      input logic [`PMSQ_LINKS_PER_TERM-1:0] k);
      logic r;
      r = 1'b1;
      for (int i = 0; i < `PMSQ_N_LITS; i++) begin
         if (k[2*i] && !l[i]) begin
            r = 1'b0;
         end
         if (k[2*i+1] && l[i]) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   // inputs, fed-back state and the complemented sum form the literals
   assign lits = {pl.c_lit, pl.base_lits};

   // first pass drops the complement literal so the feedback has no loop;
   // a term feeding the complement sum cannot itself use that literal
   always_comb begin
      logic [`PMSQ_LINKS_PER_TERM-1:0] m;
      m = '0;
      pre = '0;
      for (int t = 0; t < `PMSQ_N_PTERMS; t++) begin
         m = and_links_i[t];
         m[`PMSQ_C_LINK_LSB+1 -: 2] = 2'h0;
         pre[t] = term_of({1'b0, pl.base_lits}, m);
      end
   end

   always_comb begin
      fin = '0;
      for (int t = 0; t < `PMSQ_N_PTERMS; t++) begin
         fin[t] = term_of(lits, and_links_i[t]);
      end
   end

   assign pl.pterm_pre = pre;
   assign pl.pterm = fin;

   a_blank_term_high: assert property (
      @(posedge pl.clk)
      (and_links_i[47] == '0) |-> pl.pterm[47])
      else $error("term with no links is not high");

endmodule

// [pmsq_or_plane.sv]
/*
   programmable or plane: 12 set/reset pairs plus the complement sum.
   assumes link bit high means the link is intact.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"

module pmsq_or_plane (
   // link map
   input wire pmsq_pkg::pmsq_or_links_type or_links_i,
   // plane signals
   pmsq_plane_if.or_mp pl
);

   logic [`PMSQ_N_SR_SUMS-1:0] sums;

   // a removed link leaves its input low, so unused terms add nothing
   always_comb begin
      for (int j = 0; j < `PMSQ_N_SR_SUMS; j++) begin
         sums[j] = |(pl.pterm & or_links_i[j]);
      end
   end

   // even sum of a pair sets, odd sum resets
   always_comb begin
      for (int p = 0; p < `PMSQ_N_PAIRS; p++) begin
         pl.sum_set[p] = sums[2*p];
         pl.sum_rst[p] = sums[2*p+1];
      end
   end

   assign pl.c_lit =
      ~|(pl.pterm_pre & or_links_i[`PMSQ_C_SUM_IDX]);

   a_unlinked_sum_low: assert property (
      @(posedge pl.clk)
      (or_links_i[4] == '0) |-> !pl.sum_set[2])
      else $error("sum with no links is not low");

   a_c_term_inverts: assert property (
      @(posedge pl.clk)
      (|(pl.pterm_pre & or_links_i[`PMSQ_C_SUM_IDX])) |-> !pl.c_lit)
      else $error("complement sum not inverted");

endmodule

// [pmsq_top.sv]
/*
   programmable mealy sequencer: and/or planes, 8-bit state register,
   4-bit output register, shared preset or output control pin.
   assumes inputs synchronous to core_clk_i; link maps held static.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"

// Behaviour
// - 48 programmable product terms feed 12 programmable or-term pairs.
// - pairs drive set and reset of 8 state and 4 output bits.
// - all 8 state bits feed back with the 14 inputs as literals.
// - the two lowest state bits are also driven out.
// - one sum term is inverted and fed back as a literal.
// - both registers are set/reset flops updating on rising clock.
// - at power-up every state and output bit is high.
// - shared pin presets by default; a fuse turns it into output enable.
// - preset high blocks clocking and holds all bits high asynchronously.
// - after preset drops, the first rising edge updates normally.
// - a removed and-plane link acts as constant high.
// - a removed or-plane link acts as constant low.
module pmsq_top (
   // clock and power-up reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // programmed links and mode fuse
   input wire pmsq_pkg::pmsq_and_links_type and_links_i,
   input wire pmsq_pkg::pmsq_or_links_type or_links_i,
   input wire logic oe_mode_fuse_i,
   // external pins
   input wire logic [`PMSQ_N_INPUTS-1:0] external_inputs_i,
   input wire logic preset_oe_i,
   // registered outputs and their enables
   output logic [`PMSQ_N_OUT-1:0] registered_outputs_o,
   output logic [`PMSQ_N_OUT-1:0] registered_outputs_oe_o,
   output logic [`PMSQ_N_PIN_STATE-1:0] state_bits_o,
   output logic [`PMSQ_N_PIN_STATE-1:0] state_bits_oe_o
);

   pmsq_plane_if pl ();

   logic [`PMSQ_N_STATE-1:0] state_bits;
   logic [`PMSQ_N_OUT-1:0] registered_outputs;
   logic [`PMSQ_N_STATE-1:0] next_state_bits;
   logic [`PMSQ_N_OUT-1:0] next_registered_outputs;
   logic preset_act;
   logic out_drive;

   // set/reset flop step; both terms true is taken as hold
   function automatic logic [`PMSQ_N_STATE-1:0] sr_next(
      input logic [`PMSQ_N_STATE-1:0] q,
      input logic [`PMSQ_N_STATE-1:0] s,
      input logic [`PMSQ_N_STATE-1:0] r);
      return (s & ~r) | (q & ~(r & ~s));
   endfunction

   pmsq_and_plane u_and (
      .and_links_i(and_links_i),
      .pl(pl.and_mp)
   );

   pmsq_or_plane u_or (
      .or_links_i(or_links_i),
      .pl(pl.or_mp)
   );

   assign pl.base_lits = {state_bits, external_inputs_i};
   assign pl.clk = core_clk_i;

   // pin is a preset unless the mode fuse is blown
   assign preset_act = preset_oe_i & ~oe_mode_fuse_i;
   assign out_drive = ~(oe_mode_fuse_i & preset_oe_i);

   always_comb begin
      next_state_bits = sr_next(state_bits,
         pl.sum_set[`PMSQ_N_STATE-1:0],
         pl.sum_rst[`PMSQ_N_STATE-1:0]);
      next_registered_outputs = 4'(sr_next(
         {4'h0, registered_outputs},
         {4'h0, pl.sum_set[`PMSQ_N_PAIRS-1:`PMSQ_N_STATE]},
         {4'h0, pl.sum_rst[`PMSQ_N_PAIRS-1:`PMSQ_N_STATE]}));
   end

   // preset is a level on the async path, so clocking is simply gated
   // off while it stands and the first edge after release updates
   always_ff @(posedge core_clk_i or posedge reset_i or posedge preset_act)
   begin
      if (reset_i) begin
         state_bits <= `PMSQ_STATE_RESET;
         registered_outputs <= `PMSQ_OUT_RESET;
      end else if (preset_act) begin
         state_bits <= `PMSQ_STATE_RESET;
         registered_outputs <= `PMSQ_OUT_RESET;
      end else begin
         state_bits <= next_state_bits;
         registered_outputs <= next_registered_outputs;
      end
   end

   assign registered_outputs_o = registered_outputs;
   assign state_bits_o = state_bits[`PMSQ_N_PIN_STATE-1:0];
   // enable follows the pin without a flop, as a three-state buffer would
   assign registered_outputs_oe_o = {`PMSQ_N_OUT{out_drive}};
   assign state_bits_oe_o = {`PMSQ_N_PIN_STATE{out_drive}};

   a_state_set_high: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> ((state_bits
         & $past(pl.sum_set[7:0] & ~pl.sum_rst[7:0]))
         == $past(pl.sum_set[7:0] & ~pl.sum_rst[7:0])))
      else $error("state bit with only set did not go high");

   a_out_reset_low: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> ((registered_outputs
         & $past(pl.sum_rst[11:8] & ~pl.sum_set[11:8])) == 4'h0))
      else $error("output bit with only reset did not go low");

   a_state_idle_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (((state_bits ^ $past(state_bits))
         & ~$past(pl.sum_set[7:0] | pl.sum_rst[7:0])) == 8'h00))
      else $error("state bit changed with no set or reset");

   a_preset_all_high: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      preset_act |-> (state_bits == `PMSQ_STATE_RESET
         && registered_outputs == `PMSQ_OUT_RESET))
      else $error("preset did not hold registers high");

   a_preset_resume: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      ($past(preset_act) && !preset_act)
      |=> (state_bits == $past(next_state_bits)))
      else $error("first edge after preset did not update");

   a_pins_show_state: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (state_bits_o
         == $past(next_state_bits[`PMSQ_N_PIN_STATE-1:0])))
      else $error("state pins differ from low state bits");

   a_oe_mode_drive: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (oe_mode_fuse_i && !preset_oe_i) |-> (&registered_outputs_oe_o
         && &state_bits_oe_o))
      else $error("outputs not driven with enable low");

   a_oe_mode_float: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (oe_mode_fuse_i && preset_oe_i) |-> (registered_outputs_oe_o == 4'h0
         && !preset_act))
      else $error("enable mode pin high still drives or presets");

   a_out_set_high: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> ((registered_outputs
         & $past(pl.sum_set[11:8] & ~pl.sum_rst[11:8]))
         == $past(pl.sum_set[11:8] & ~pl.sum_rst[11:8])))
      else $error("output bit with only set did not go high");

   a_state_reset_low: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> ((state_bits
         & $past(pl.sum_rst[7:0] & ~pl.sum_set[7:0])) == 8'h00))
      else $error("state bit with only reset did not go low");

   a_out_idle_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (((registered_outputs
         ^ $past(registered_outputs))
         & ~$past(pl.sum_set[11:8] | pl.sum_rst[11:8])) == 4'h0))
      else $error("output bit changed with no set or reset");

   a_state_both_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (((state_bits ^ $past(state_bits))
         & $past(pl.sum_set[7:0] & pl.sum_rst[7:0])) == 8'h00))
      else $error("state bit with set and reset did not hold");

   a_out_both_hold: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (((registered_outputs
         ^ $past(registered_outputs))
         & $past(pl.sum_set[11:8] & pl.sum_rst[11:8])) == 4'h0))
      else $error("output bit with set and reset did not hold");

   // the first edge of the run may meet flops still unknown, so skip it
   a_reset_all_high: assert property (
      @(posedge core_clk_i)
      ($past(reset_i) && reset_i) |-> (state_bits == `PMSQ_STATE_RESET
         && registered_outputs == `PMSQ_OUT_RESET))
      else $error("reset did not hold registers high");

   a_reset_pins_high: assert property (
      @(posedge core_clk_i)
      ($past(reset_i) && reset_i) |-> (registered_outputs_o
         == `PMSQ_OUT_RESET && state_bits_o == 2'h3))
      else $error("reset did not show high on the pins");

   a_preset_pins_high: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      preset_act |-> (registered_outputs_o == `PMSQ_OUT_RESET
         && state_bits_o == 2'h3))
      else $error("preset did not show high on the pins");

   a_preset_mode_drive: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !oe_mode_fuse_i |-> (&registered_outputs_oe_o && &state_bits_oe_o))
      else $error("preset mode let the outputs float");

   a_preset_mode_act: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (!oe_mode_fuse_i && preset_oe_i) |-> preset_act)
      else $error("pin high in preset mode did not preset");

   a_out_resume: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      ($past(preset_act) && !preset_act)
      |=> (registered_outputs == $past(next_registered_outputs)))
      else $error("first edge after preset left outputs alone");

   a_reset_resume: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      ($past(reset_i) && !reset_i)
      |=> (state_bits == $past(next_state_bits)))
      else $error("first edge after reset did not update");

   a_oe_float_state: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (oe_mode_fuse_i && preset_oe_i) |-> (state_bits_oe_o == 2'h0))
      else $error("state pins driven with enable high");

   a_oe_mode_updates: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (oe_mode_fuse_i && preset_oe_i)
      |=> (state_bits == $past(next_state_bits)))
      else $error("enable mode pin high blocked clocking");

   a_state_next: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act) |=> (state_bits == $past(next_state_bits)))
      else $error("state register missed a rising edge");

   a_out_next: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act)
      |=> (registered_outputs == $past(next_registered_outputs)))
      else $error("output register missed a rising edge");

   a_state_pin_set: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act && pl.sum_set[0] && !pl.sum_rst[0])
      |=> state_bits_o[0])
      else $error("state pin did not follow its set term");

   a_state_pin_clear: assert property (
      @(posedge core_clk_i) disable iff (reset_i || preset_act)
      (!reset_i && !preset_act && pl.sum_rst[1] && !pl.sum_set[1])
      |=> !state_bits_o[1])
      else $error("state pin did not follow its reset term");

endmodule

// [pmsq_far_model.sv]
/*
   far-side logic model: drives the sequencer's inputs and shared pin.
   assumes the bench hands it requests at the rising clock edge.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"

module pmsq_far_model (
   // requests from the bench
   input wire logic [`PMSQ_N_INPUTS-1:0] ins_req_i,
   input wire logic pre_req_i,
   // pins toward the sequencer
   output logic [`PMSQ_N_INPUTS-1:0] external_inputs_o,
   output logic preset_oe_o
);
   // plain wires: surrounding logic owns no extra delay here
   assign external_inputs_o = ins_req_i;
   assign preset_oe_o = pre_req_i;
endmodule

// [programmable_mealy_sequencer_tb_top.sv]
/*
   self-checking bench of the mealy sequencer with a small program.
   assumes pmsq_top and the far model; preset pin drives every register.
*/
`timescale 1ns/100ps
`include "pmsq_consts.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
   n_errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end

module programmable_mealy_sequencer_tb_top;
   typedef struct packed {
      logic [13:0] ins;
      logic [1:0] st;
      logic [3:0] q;
   } pmsq_row_type;
   logic core_clk_i, reset_i, fuse, pre_req, pre_pin;
   logic [13:0] ins_req, ext;
   pmsq_pkg::pmsq_and_links_type and_links;
   pmsq_pkg::pmsq_or_links_type or_links;
   logic [3:0] q, q_oe;
   logic [1:0] st, st_oe;
   int n_errors, check_count, cyc;
   pmsq_row_type rows [9];

   pmsq_far_model far (.ins_req_i(ins_req), .pre_req_i(pre_req),
      .external_inputs_o(ext), .preset_oe_o(pre_pin));
   pmsq_top uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .and_links_i(and_links), .or_links_i(or_links),
      .oe_mode_fuse_i(fuse), .external_inputs_i(ext),
      .preset_oe_i(pre_pin), .registered_outputs_o(q),
      .registered_outputs_oe_o(q_oe), .state_bits_o(st),
      .state_bits_oe_o(st_oe));

   task conclude;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // ceiling well above the few dozen cycles the tests need
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      reset_i = 1'b1;
      fuse = 1'b0;
      pre_req = 1'b0;
      ins_req = '0;
      and_links = '0;
      or_links = '0;
      // terms 0..6 keep one input literal, term 4 adds the complement and term 5 state bit 0; others have no links at all
      for (int t = 0; t < 7; t++) and_links[t][2*t] = 1'b1;
      and_links[4][44] = 1'b1;
      and_links[5][28] = 1'b1;
      or_links[0][0] = 1'b1;
      or_links[1][1] = 1'b1;
      or_links[16][2] = 1'b1;
      or_links[24][2] = 1'b1;
      or_links[17][3] = 1'b1;
      or_links[3][4] = 1'b1;
      or_links[19][5] = 1'b1;
      or_links[2][6] = 1'b1;
      rows = '{'{14'h0000, 2'h3, 4'hf}, '{14'h0002, 2'h2, 4'hf},
         '{14'h0008, 2'h2, 4'he}, '{14'h0021, 2'h3, 4'he},
         '{14'h0020, 2'h3, 4'hc}, '{14'h0010, 2'h1, 4'hc},
         '{14'h0014, 2'h1, 4'hd}, '{14'h0044, 2'h3, 4'hd},
         '{14'h0003, 2'h3, 4'hd}};
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      ins_req <= rows[0].ins;
      // each row is sampled by the edge after the one that drove it
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk_i);
         ins_req <= (i < 8) ? rows[i + 1].ins : 14'h0000;
         #1;
         `CHK("state", rows[i].st, st)
         `CHK("out", rows[i].q, q)
         `CHK("oe", 4'hf, q_oe)
      end
      // preset while reset terms are live: blocked, all high at once
      @(posedge core_clk_i);
      pre_req <= 1'b1;
      ins_req <= 14'h000a;
      #1;
      `CHK("pre_out", 4'hf, q)
      repeat (3) @(posedge core_clk_i);
      #1;
      `CHK("pre_state", 2'h3, st)
      `CHK("pre_out2", 4'hf, q)
      @(posedge core_clk_i);
      pre_req <= 1'b0;
      @(posedge core_clk_i);
      #1;
      `CHK("rec_state", 2'h2, st)
      `CHK("rec_out", 4'he, q)
      // asynchronous power-up reset, seen before any edge
      repeat (2) @(posedge core_clk_i);
      ins_req <= '0;
      reset_i <= 1'b1;
      #1;
      `CHK("rst_state", 2'h3, st)
      `CHK("rst_out", 4'hf, q)
      @(posedge core_clk_i);
      reset_i <= 1'b0;
      // enable mode: pin high floats outputs but does not preset
      @(posedge core_clk_i);
      fuse <= 1'b1;
      pre_req <= 1'b1;
      ins_req <= 14'h0002;
      #1;
      `CHK("oe_off", 4'h0, q_oe)
      `CHK("oe_st_off", 2'h0, st_oe)
      @(posedge core_clk_i);
      ins_req <= '0;
      #1;
      `CHK("oe_state", 2'h2, st)
      @(posedge core_clk_i);
      pre_req <= 1'b0;
      #1;
      `CHK("oe_on", 4'hf, q_oe)
      `CHK("oe_st_on", 2'h3, st_oe)
      repeat (2) @(posedge core_clk_i);
      conclude();
   end
endmodule
